// file: hw/charger_status_consts.vh
// Constants for the charger status selector
`ifndef CHARGER_STATUS_CONSTS_VH
`define CHARGER_STATUS_CONSTS_VH
// -----------------------------------------------
// Register map
// -----------------------------------------------
`define REG_CTRL          8'h12
`define REG_STATUS        8'h13
`define REG_CHG_SET       8'h14
`define REG_DEPLETE       8'h15
`define REG_IRQ_STATUS    8'h16
`define REG_IRQ_MASK      8'h17
// -----------------------------------------------
// Field positions
// -----------------------------------------------
`define CTRL_ENABLE       0
`define CTRL_LEARN        1
`define ST_INPUT_IDLE     4
`define ST_CHG_OC         5
`define ST_PACK_ON_LOAD   6
`define IRQ_OC            0
`define IRQ_PACK_CHANGE   1
`define IRQ_WIDTH         2
// -----------------------------------------------
// Thresholds and resets
// -----------------------------------------------
`define OC_NUM            17
`define OC_DEN            10
`define REVERSE_MV        150
`define CTRL_RESET        16'h0000
`define MASK_RESET        2'h0
`endif

// file: hw/pulse_sync_latch.v
// Switching-cycle retry latch for the high-side switch
`timescale 1ns/1ps
module pulse_sync_latch (
   input  wire i_clk,
   input  wire i_arst_n,
   input  wire i_trip,
   input  wire i_cycle_start,
   output reg  o_off
);
   // Off from the trip until the next cycle start
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_off <= 1'b0;
      end else if (i_trip) begin
         o_off <= 1'b1;
      end else if (i_cycle_start) begin
         o_off <= 1'b0;
      end
   end
endmodule // pulse_sync_latch

// file: hw/charger_status_selector.v
// Status bits 4..6 of the charger with pack selector and fault alarm
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "charger_status_consts.vh"
module charger_status_selector #(
   parameter CW = 16,
   parameter MW = 16
) (
   input  wire          i_clk,
   input  wire          i_arst_n,
   input  wire [7:0]    i_addr,
   input  wire [15:0]   i_wdata,
   input  wire          i_wr,
   input  wire          i_rd,
   output reg  [15:0]   o_rdata,
   input  wire          i_input_power_limiting,
   input  wire [CW-1:0] i_charge_current,
   input  wire          i_adapter_present,
   input  wire [MW-1:0] i_pack_mv,
   input  wire [MW-1:0] i_load_rail_mv,
   input  wire          i_cycle_start,
   output wire          o_high_side_on,
   output wire          o_pack_switch_drive,
   output wire          o_alarm,
   output wire          o_irq
);
   // -----------------------------------------------
   // Registers
   // -----------------------------------------------
   reg  [15:0]   ctrl;
   reg  [CW-1:0] chg_set;
   reg  [MW-1:0] pack_depleted_threshold;
   reg  [`IRQ_WIDTH-1:0] irq_status;
   reg  [`IRQ_WIDTH-1:0] irq_mask;
   reg           input_limit_loop_idle;
   reg           charge_overcurrent_flag;
   reg           pack_drive;
   reg           depleted;
   wire          enable;
   wire          learn;
   wire          hs_off;
   wire          trip;
   wire          next_pack;
   wire          reverse;
   wire [CW+4:0] cur_x10;
   wire [CW+4:0] lim_x10;
   wire [MW:0]   pack_plus;
   wire [`IRQ_WIDTH-1:0] events;
   wire          rd_irq;
   // Sized copies of the thresholds keep the products at target width
   localparam [CW+4:0] OC_DEN_W  = `OC_DEN;
   localparam [CW+4:0] OC_NUM_W  = `OC_NUM;
   localparam [MW:0]   REVERSE_W = `REVERSE_MV;

   assign enable = ctrl[`CTRL_ENABLE];
   assign learn  = ctrl[`CTRL_LEARN];

   // -----------------------------------------------
   // Overcurrent detect and retry
   // -----------------------------------------------
   // Integer compare avoids a fractional multiplier
   assign cur_x10 = {5'b00000, i_charge_current} * OC_DEN_W;
   assign lim_x10 = {5'b00000, chg_set} * OC_NUM_W;
   assign trip    = enable && (cur_x10 > lim_x10);

   pulse_sync_latch u_retry (
      .i_clk         (i_clk),
      .i_arst_n      (i_arst_n),
      .i_trip        (trip),
      .i_cycle_start (i_cycle_start),
      .o_off         (hs_off)
   );

   // Trip gates the switch in the same cycle, latch holds it off
   assign o_high_side_on = enable && !trip && !hs_off;
   assign o_alarm        = charge_overcurrent_flag;

   // -----------------------------------------------
   // Pack selector
   // -----------------------------------------------
   assign pack_plus = {1'b0, i_pack_mv} + REVERSE_W;
   assign reverse   = {1'b0, i_load_rail_mv} > pack_plus;
   assign next_pack = !reverse &&
                      (!i_adapter_present ||
                       (learn && !depleted));

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         depleted <= 1'b0;
         pack_drive <= 1'b0;
         input_limit_loop_idle <= 1'b1;
         charge_overcurrent_flag <= 1'b0;
      end else begin
         // Depletion latches until learn mode is left or the adapter is removed
         if (!learn || !i_adapter_present) begin
            depleted <= 1'b0;
         end else if (i_pack_mv < pack_depleted_threshold) begin
            depleted <= 1'b1;
         end
         pack_drive <= next_pack;
         input_limit_loop_idle <= !(enable && i_input_power_limiting);
         charge_overcurrent_flag <= trip;
      end
   end

   assign o_pack_switch_drive = pack_drive;

   // -----------------------------------------------
   // Interrupts
   // -----------------------------------------------
   assign events[`IRQ_OC]          = trip && !charge_overcurrent_flag;
   assign events[`IRQ_PACK_CHANGE] = next_pack != pack_drive;
   assign rd_irq = i_rd && (i_addr == `REG_IRQ_STATUS);

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_status <= {`IRQ_WIDTH{1'b0}};
      end else begin
         // Set wins over read clear
         irq_status <= (rd_irq ? {`IRQ_WIDTH{1'b0}} : irq_status) | events;
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   // -----------------------------------------------
   // Register port
   // -----------------------------------------------
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl <= `CTRL_RESET;
         chg_set <= {CW{1'b0}};
         pack_depleted_threshold <= {MW{1'b0}};
         irq_mask <= `MASK_RESET;
      end else if (i_wr) begin
         case (i_addr)
            `REG_CTRL: begin
               ctrl <= i_wdata;
            end
            `REG_CHG_SET: begin
               chg_set <= i_wdata[CW-1:0];
            end
            `REG_DEPLETE: begin
               pack_depleted_threshold <= i_wdata[MW-1:0];
            end
            `REG_IRQ_MASK: begin
               irq_mask <= i_wdata[`IRQ_WIDTH-1:0];
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= 16'h0000;
         case (i_addr)
            `REG_CTRL: begin
               o_rdata <= ctrl;
            end
            `REG_STATUS: begin
               o_rdata[`ST_INPUT_IDLE]   <= input_limit_loop_idle;
               o_rdata[`ST_CHG_OC]       <= charge_overcurrent_flag;
               o_rdata[`ST_PACK_ON_LOAD] <= pack_drive;
            end
            `REG_CHG_SET: begin
               o_rdata[CW-1:0] <= chg_set;
            end
            `REG_DEPLETE: begin
               o_rdata[MW-1:0] <= pack_depleted_threshold;
            end
            `REG_IRQ_STATUS: begin
               o_rdata[`IRQ_WIDTH-1:0] <= irq_status;
            end
            `REG_IRQ_MASK: begin
               o_rdata[`IRQ_WIDTH-1:0] <= irq_mask;
            end
            default: begin
               o_rdata <= 16'h0000;
            end
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end
endmodule // charger_status_selector

// file: verification/charger_status_monitor.sv
// Port checks for the charger status selector
`timescale 1ns/1ps
module charger_status_monitor #(
   parameter MW = 16
) (
   input wire          i_clk,
   input wire          i_arst_n,
   input wire          i_rd,
   input wire          i_cycle_start,
   input wire          i_adapter_present,
   input wire [7:0]    i_addr,
   input wire [15:0]   o_rdata,
   input wire [MW-1:0] i_pack_mv,
   input wire [MW-1:0] i_load_rail_mv,
   input wire          o_high_side_on,
   input wire          o_pack_switch_drive,
   input wire          o_alarm
);
   wire [MW:0] lim = i_pack_mv + 17'h00096;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   sequence held_off;
      o_alarm && !o_high_side_on && !i_cycle_start;
   endsequence
   a_trip_off: assert property (o_alarm |-> !$past(o_high_side_on))
      else $error("high side on in trip cycle");
   a_hold_off: assert property (held_off |=> !o_high_side_on)
      else $error("high side on before cycle start");
   a_retry_start: assert property (o_high_side_on && !$past(o_high_side_on)
      && $past(o_alarm) |-> $past(i_cycle_start))
      else $error("retry without cycle start");
   a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside read slot");
   a_st_bits: assert property ($past(i_rd) && $past(i_addr) == 8'h13
      |-> o_rdata[6:5] == {$past(o_pack_switch_drive), $past(o_alarm)})
      else $error("status bits differ from outputs");
   a_st_unused: assert property ($past(i_rd) && $past(i_addr) == 8'h13
      |-> o_rdata[15:7] == 9'h000 && o_rdata[3:0] == 4'h0)
      else $error("status unused bits set");
   a_reverse_off: assert property ({1'b0, i_load_rail_mv} > lim
      |=> !o_pack_switch_drive)
      else $error("pack on with rail above pack");
   a_no_adapter: assert property (!i_adapter_present
      && {1'b0, i_load_rail_mv} <= lim |=> o_pack_switch_drive)
      else $error("pack off without adapter");
endmodule // charger_status_monitor

// file: verification/host_model.sv
// Host controller model issuing register cycles
`timescale 1ns/1ps
module host_model (
   input  wire         i_clk,
   output logic [7:0]  o_addr = 8'h00,
   output logic [15:0] o_wdata = 16'h0000,
   output logic        o_wr = 1'b0,
   output logic        o_rd = 1'b0,
   input  wire  [15:0] i_rdata
);
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask
   // Data stands one cycle only; taken at the edge that ends it
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      d = i_rdata;
   endtask
endmodule // host_model

// file: verification/tb_top.sv
// Self-checking bench for the charger status selector
`timescale 1ns/1ps
module tb_top;
   logic        i_clk = 1'b0, i_arst_n = 1'b0, i_wr, i_rd;
   logic        i_input_power_limiting = 1'b0, i_adapter_present = 1'b1;
   logic        i_cycle_start = 1'b0;
   logic [7:0]  i_addr;
   logic [15:0] i_wdata, o_rdata, rd_val, i_charge_current = 16'h0000;
   logic [15:0] i_pack_mv = 16'h0000, i_load_rail_mv = 16'h0000;
   wire         o_high_side_on, o_pack_switch_drive, o_alarm, o_irq;
   int          mismatches = 0, n_tests = 0;
   // Adapter, learn, pack, rail, expected drive
   logic [34:0] rows [5] = '{{2'b00, 16'h2EE0, 16'h2EE0, 1'b1},
      {2'b00, 16'h2EE0, 16'h2F77, 1'b0}, {2'b00, 16'h2EE0, 16'h2F76, 1'b1},
      {2'b10, 16'h2EE0, 16'h2EE0, 1'b0}, {2'b11, 16'h2EE0, 16'h2EE0, 1'b1}};
   always #2.5 i_clk = ~i_clk;
   charger_status_selector dut_u (.*);
   host_model host_u (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata),
      .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata));
   task automatic chk(input string n, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic final_report;
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   initial begin
      #20000;
      mismatches++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      host_u.rd(8'h13, rd_val);
      chk("status", rd_val, 16'h0010);
      host_u.rd(8'h20, rd_val);
      chk("unmapped", rd_val, 16'h0000);
      host_u.wr(8'h15, 16'h2710);
      foreach (rows[i]) begin
         host_u.wr(8'h12, {14'h0000, rows[i][33], 1'b0});
         i_adapter_present <= rows[i][34];
         i_pack_mv <= rows[i][32:17];
         i_load_rail_mv <= rows[i][16:1];
         cyc(2);
         chk("drive", o_pack_switch_drive, rows[i][0]);
         host_u.rd(8'h13, rd_val);
         chk("pack bit", rd_val[6], rows[i][0]);
      end
      i_pack_mv <= 16'h2328;
      i_load_rail_mv <= 16'h2328;
      cyc(2);
      chk("depleted", o_pack_switch_drive, 1'b0);
      host_u.rd(8'h16, rd_val);
      host_u.wr(8'h17, 16'h0001);
      host_u.wr(8'h14, 16'h0064);
      host_u.wr(8'h12, 16'h0001);
      i_input_power_limiting <= 1'b1;
      i_charge_current <= 16'h00AA;
      cyc(2);
      chk("high side", o_high_side_on, 1'b1);
      host_u.rd(8'h13, rd_val);
      chk("status", rd_val, 16'h0000);
      i_charge_current <= 16'h00AB;
      #1 chk("high side", o_high_side_on, 1'b0);
      cyc(2);
      chk("alarm", o_alarm, 1'b1);
      chk("irq", o_irq, 1'b1);
      host_u.rd(8'h13, rd_val);
      chk("status", rd_val, 16'h0020);
      i_charge_current <= 16'h0064;
      cyc(3);
      chk("high side", o_high_side_on, 1'b0);
      i_cycle_start <= 1'b1;
      cyc(1);
      i_cycle_start <= 1'b0;
      chk("high side", o_high_side_on, 1'b1);
      host_u.rd(8'h16, rd_val);
      chk("irq status", rd_val, 16'h0001);
      cyc(1);
      chk("irq", o_irq, 1'b0);
      final_report;
   end
endmodule // tb_top
bind charger_status_selector charger_status_monitor #(.MW(MW)) mon_u (.*);
